//--- core/ppo_pkg.sv
// Shared constants and types of the port pin override logic.
// Assumes one eight-pin port with alternate functions on every pin.
package ppo_pkg;

    // ------------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------------
    localparam int PPO_PINS = 8;

    // Reset values of the direction and output registers.
    localparam logic [PPO_PINS-1:0] PPO_DIR_RESET = 8'h00;
    localparam logic [PPO_PINS-1:0] PPO_OUT_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Alternate function bit positions on the second port
    // ------------------------------------------------------------------
    localparam int PPO_BIT_CRYSTAL_OUT = 7;
    localparam int PPO_BIT_CRYSTAL_IN = 6;
    localparam int PPO_BIT_SPI_CLOCK = 5;
    localparam int PPO_BIT_SPI_MISO = 4;
    localparam int PPO_BIT_SPI_MOSI = 3;
    localparam int PPO_BIT_SPI_SELECT = 2;
    localparam int PPO_BIT_TIMER2_CMP_A = 3;
    localparam int PPO_BIT_TIMER1_CMP_B = 2;
    localparam int PPO_BIT_TIMER1_CMP_A = 1;
    localparam int PPO_BIT_CAPTURE_IN = 0;
    localparam int PPO_BIT_DIV_CLOCK_OUT = 0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Which port register a read strobe selects.
    typedef enum logic [1:0]
    {
        PPO_RD_DIRECTION,
        PPO_RD_OUTPUT,
        PPO_RD_INPUT
    } ppo_read_sel_t;

    // Override signals a peripheral presents for one pin.
    typedef struct packed
    {
        logic pullup_override_en;
        logic pullup_override_val;
        logic direction_override_en;
        logic direction_override_val;
        logic value_override_en;
        logic value_override_val;
        logic toggle_override_en;
        logic input_enable_override_en;
        logic input_enable_override_val;
    } ppo_override_t;

    // Clock source selection that decides whether bit 7 is a clock pin.
    typedef struct packed
    {
        logic crystal_osc_select;
        logic internal_rc_select;
        logic async_timer_enable;
        logic external_clock_select;
    } ppo_clock_cfg_t;

endpackage

//--- core/ppo_port_pin_override.sv
// Pin control of one bidirectional port whose pins are shared with
// on-chip peripherals through per-pin override signals.
// Assumes peripherals and the sleep controller run on clk_sys_i and the
// pad inputs arrive asynchronously from the pins.
//
// Overview of operation
// - Sleep clamps pin inputs to ground.
// - Sleep never clamps enabled external interrupt pins.
// - Clamp release on high pin raises edge.
// - Pull-ups stay off while reset is active.
// - Pull-up follows override or dir/out/disable 010.
// - Driver enable follows direction override or bit.
// - Driven value follows value override or bit.
// - Toggle override inverts the output register bit.
// - Input enable override beats sleep state.
// - Raw unsynchronized input goes to peripherals.
// - Strobes per port, overrides per pin.
// - Second port alternate functions mapped by bit.
// - Each pin is pin change source n.
// - Bit 7 as crystal pin leaves I/O.
// - Timer oscillator detaches bit 7 when selected.
// - Clock pin bit 7 reads back zero.
// - Direction one means output, zero input.
// - Writing one to input register toggles output.
// - Global disable kills non-overridden pull-ups.
// - Half-cycle latch plus flop input synchronizer.

`timescale 1ns/1ps

module ppo_port_pin_override
#(
    parameter int WIDTH = ppo_pkg::PPO_PINS
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Port-wide write strobes and data, shared by every pin.
    input wire logic dir_write_strobe_i,
    input wire logic out_write_strobe_i,
    input wire logic in_write_strobe_i,
    input wire logic [WIDTH-1:0] write_data_i,
    // Port-wide read strobe and selection.
    input wire logic port_read_strobe_i,
    input wire ppo_pkg::ppo_read_sel_t read_sel_i,
    output logic [WIDTH-1:0] read_data_o,
    // Signals shared by all ports.
    input wire logic sleep_i,
    input wire logic global_pullup_disable_i,
    input wire ppo_pkg::ppo_clock_cfg_t clock_cfg_i,
    // Per-pin signals.
    input wire ppo_pkg::ppo_override_t override_i [WIDTH],
    input wire logic [WIDTH-1:0] ext_int_enable_i,
    input wire logic [WIDTH-1:0] pad_in_i,
    output logic [WIDTH-1:0] pad_out_o,
    output logic [WIDTH-1:0] pad_oe_o,
    output logic [WIDTH-1:0] pullup_en_o,
    output logic [WIDTH-1:0] raw_digital_input_o,
    output logic [WIDTH-1:0] pin_change_source_o,
    output logic osc_amp_output_o,
    output logic [WIDTH-1:0] pin_direction_bit_o,
    output logic [WIDTH-1:0] pin_output_bit_o,
    output logic [WIDTH-1:0] pin_input_bit_o
);
    import ppo_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] pin_direction_bit;
    logic [WIDTH-1:0] pin_output_bit;
    logic [WIDTH-1:0] next_pin_output_bit;
    logic [WIDTH-1:0] sync_latch;
    logic [WIDTH-1:0] pin_input_bit;
    logic [WIDTH-1:0] toggle_req;
    logic [WIDTH-1:0] input_enable;
    logic [WIDTH-1:0] clock_pin_mask;
    logic [WIDTH-1:0] read_mask;
    logic crystal_pin;
    logic timer_osc_pin;
    logic bit7_is_clock;

    // ------------------------------------------------------------------
    // Bit 7 clock pin detection
    // ------------------------------------------------------------------
    // A crystal oscillator takes the pin whenever it is the chip clock.
    // The timer oscillator only claims it under the internal RC clock,
    // with the asynchronous timer on and no external clock selected.
    always_comb
    begin
        crystal_pin = clock_cfg_i.crystal_osc_select;
        timer_osc_pin = clock_cfg_i.internal_rc_select
            & clock_cfg_i.async_timer_enable
            & ~clock_cfg_i.external_clock_select;
        bit7_is_clock = crystal_pin | timer_osc_pin;
    end

    assign osc_amp_output_o = timer_osc_pin;

    always_comb
    begin
        clock_pin_mask = '0;
        clock_pin_mask[PPO_BIT_CRYSTAL_OUT] = bit7_is_clock;
        read_mask = ~clock_pin_mask;
    end

    // ------------------------------------------------------------------
    // Direction register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pin_direction_bit <= PPO_DIR_RESET;
        end
        else if (dir_write_strobe_i)
        begin
            pin_direction_bit <= write_data_i;
        end
    end

    // ------------------------------------------------------------------
    // Output register with toggle
    // ------------------------------------------------------------------
    // A toggle from a written one and a toggle from an override in the
    // same cycle both act, so one flips the bit and two cancel. A written
    // output value is loaded first and the toggles then apply to it.
    always_comb
    begin
        for (int n = 0; n < WIDTH; n++)
        begin
            toggle_req[n] = override_i[n].toggle_override_en;
        end
        if (out_write_strobe_i)
        begin
            next_pin_output_bit = write_data_i;
        end
        else
        begin
            next_pin_output_bit = pin_output_bit;
        end
        if (in_write_strobe_i)
        begin
            next_pin_output_bit = next_pin_output_bit ^ write_data_i;
        end
        next_pin_output_bit = next_pin_output_bit ^ toggle_req;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pin_output_bit <= PPO_OUT_RESET;
        end
        else
        begin
            pin_output_bit <= next_pin_output_bit;
        end
    end

    // ------------------------------------------------------------------
    // Per-pin control
    // ------------------------------------------------------------------
    generate
        for (genvar n = 0; n < WIDTH; n++)
        begin : g_pin
            ppo_override_t ovr;
            logic detach;
            logic dir_eff;
            logic pullup_normal;

            assign ovr = override_i[n];
            assign detach = clock_pin_mask[n];

            // Output driver: direction one drives, zero leaves the pin
            // to the outside world.
            always_comb
            begin
                if (ovr.direction_override_en)
                begin
                    dir_eff = ovr.direction_override_val;
                end
                else
                begin
                    dir_eff = pin_direction_bit[n];
                end
                pad_oe_o[n] = dir_eff & ~detach;
                if (!pad_oe_o[n])
                begin
                    pad_out_o[n] = 1'b0;
                end
                else if (ovr.value_override_en)
                begin
                    pad_out_o[n] = ovr.value_override_val;
                end
                else
                begin
                    pad_out_o[n] = pin_output_bit[n];
                end
            end

            // Pull-up is held off through reset because the stored
            // output bit may still carry an old enable until it clears.
            always_comb
            begin
                pullup_normal = ~pin_direction_bit[n]
                    & pin_output_bit[n]
                    & ~global_pullup_disable_i;
                if (rst_i || detach)
                begin
                    pullup_en_o[n] = 1'b0;
                end
                else if (ovr.pullup_override_en)
                begin
                    pullup_en_o[n] = ovr.pullup_override_val;
                end
                else
                begin
                    pullup_en_o[n] = pullup_normal;
                end
            end

            // Digital input enable. Sleep clamps the input to ground
            // unless an external interrupt on the pin is armed; leaving
            // sleep with the pin high therefore yields a rising edge.
            always_comb
            begin
                if (ovr.input_enable_override_en)
                begin
                    input_enable[n] = ovr.input_enable_override_val;
                end
                else
                begin
                    input_enable[n] = ~sleep_i
                        | ext_int_enable_i[n];
                end
            end

            // The clamped Schmitt output goes straight to peripherals,
            // which must synchronise it unless they use it as a clock.
            assign raw_digital_input_o[n] = pad_in_i[n]
                & input_enable[n] & ~detach;
            assign pin_change_source_o[n] = raw_digital_input_o[n];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------------
    // The falling-edge stage stands in for the transparent-high latch,
    // giving a half to one and a half period delay to the input bit.
    always_ff @(negedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sync_latch <= '0;
        end
        else
        begin
            sync_latch <= raw_digital_input_o;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pin_input_bit <= '0;
        end
        else
        begin
            pin_input_bit <= sync_latch;
        end
    end

    // ------------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------------
    assign pin_direction_bit_o = pin_direction_bit & read_mask;
    assign pin_output_bit_o = pin_output_bit & read_mask;
    assign pin_input_bit_o = pin_input_bit & read_mask;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            read_data_o <= '0;
        end
        else if (port_read_strobe_i)
        begin
            unique case (read_sel_i)
                PPO_RD_DIRECTION: read_data_o <= pin_direction_bit_o;
                PPO_RD_OUTPUT: read_data_o <= pin_output_bit_o;
                PPO_RD_INPUT: read_data_o <= pin_input_bit_o;
                default: read_data_o <= '0;
            endcase
        end
    end

endmodule

//--- sim/ppo_checker.sv
// Concurrent checks on the ports of the port pin override logic.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module ppo_checker
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic out_write_strobe_i,
    input wire logic in_write_strobe_i,
    input wire logic [WIDTH-1:0] write_data_i,
    input wire logic sleep_i,
    input wire logic global_pullup_disable_i,
    input wire ppo_pkg::ppo_clock_cfg_t clock_cfg_i,
    input wire ppo_pkg::ppo_override_t override_i [WIDTH],
    input wire logic [WIDTH-1:0] ext_int_enable_i,
    input wire logic [WIDTH-1:0] pad_in_i,
    input wire logic [WIDTH-1:0] pad_out_o,
    input wire logic [WIDTH-1:0] pad_oe_o,
    input wire logic [WIDTH-1:0] pullup_en_o,
    input wire logic [WIDTH-1:0] raw_digital_input_o,
    input wire logic [WIDTH-1:0] pin_change_source_o,
    input wire logic osc_amp_output_o,
    input wire logic [WIDTH-1:0] pin_direction_bit_o,
    input wire logic [WIDTH-1:0] pin_output_bit_o,
    input wire logic [WIDTH-1:0] pin_input_bit_o
);
    import ppo_pkg::*;

    // ------------------------------------------------------------------
    // Expected pin controls
    // ------------------------------------------------------------------
    logic det;
    logic osc;
    logic [WIDTH-1:0] m7, pu_x, oe_x, val_x, ie_x, tv;

    assign osc = clock_cfg_i.internal_rc_select
        & clock_cfg_i.async_timer_enable & ~clock_cfg_i.external_clock_select;
    assign det = clock_cfg_i.crystal_osc_select | osc;
    assign m7 = {det, 7'h00};

    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            pu_x[i] = override_i[i].pullup_override_en
                ? override_i[i].pullup_override_val
                : ~pin_direction_bit_o[i] & pin_output_bit_o[i]
                  & ~global_pullup_disable_i;
            oe_x[i] = override_i[i].direction_override_en
                ? override_i[i].direction_override_val
                : pin_direction_bit_o[i];
            val_x[i] = override_i[i].value_override_en
                ? override_i[i].value_override_val : pin_output_bit_o[i];
            ie_x[i] = override_i[i].input_enable_override_en
                ? override_i[i].input_enable_override_val
                : ~sleep_i | ext_int_enable_i[i];
            tv[i] = (in_write_strobe_i & write_data_i[i])
                ^ override_i[i].toggle_override_en;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking

    sequence s_quiet_input;
        !rst_i && !sleep_i && $stable(pad_in_i);
    endsequence

    chk_pullup_reset: assert property (rst_i |-> pullup_en_o == '0)
        else $error("pull-up on during reset");
    chk_pullup_select: assert property (!rst_i |-> pullup_en_o == (pu_x & ~m7))
        else $error("pull-up enable differs");
    // The registers are unknown until the first reset edge, so the pin
    // equations are only compared once reset has let go.
    chk_driver_select: assert property (
        disable iff (rst_i) pad_oe_o == (oe_x & ~m7))
        else $error("driver enable differs");
    chk_drive_value: assert property (
        disable iff (rst_i) pad_out_o == (pad_oe_o & val_x))
        else $error("driven value differs");
    chk_input_gate: assert property (
        disable iff (rst_i)
        raw_digital_input_o == (pad_in_i & ie_x & ~m7)
        && pin_change_source_o == raw_digital_input_o)
        else $error("digital input gating differs");
    chk_sync_delay: assert property (s_quiet_input ##1 s_quiet_input |-> pin_input_bit_o == (pad_in_i & ~m7))
        else $error("synchronized input differs");
    chk_output_update: assert property (!rst_i && !out_write_strobe_i |=> pin_output_bit_o[6:0] == ($past(pin_output_bit_o[6:0]) ^ $past(tv[6:0])))
        else $error("output register update differs");
    chk_reset_clear: assert property (rst_i |=> pin_direction_bit_o == '0 && pin_output_bit_o == '0)
        else $error("registers not cleared by reset");
    chk_clock_pin: assert property (det |-> !pin_direction_bit_o[7] && !pin_output_bit_o[7] && !pin_input_bit_o[7])
        else $error("clock pin reads not zero");
    chk_osc_output: assert property (osc_amp_output_o == osc)
        else $error("oscillator output select differs");
endmodule

bind ppo_port_pin_override ppo_checker #(.WIDTH(WIDTH)) u_ppo_checker
(
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .out_write_strobe_i(out_write_strobe_i),
    .in_write_strobe_i(in_write_strobe_i),
    .write_data_i(write_data_i),
    .sleep_i(sleep_i),
    .global_pullup_disable_i(global_pullup_disable_i),
    .clock_cfg_i(clock_cfg_i),
    .override_i(override_i),
    .ext_int_enable_i(ext_int_enable_i),
    .pad_in_i(pad_in_i),
    .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o),
    .pullup_en_o(pullup_en_o),
    .raw_digital_input_o(raw_digital_input_o),
    .pin_change_source_o(pin_change_source_o),
    .osc_amp_output_o(osc_amp_output_o),
    .pin_direction_bit_o(pin_direction_bit_o),
    .pin_output_bit_o(pin_output_bit_o),
    .pin_input_bit_o(pin_input_bit_o)
);

//--- sim/ppo_peripheral_model.sv
// Stand-in for the peripherals that present per-pin override signals.
// Assumes the bench changes the mode just after a rising clock edge.
`timescale 1ns/1ps

module ppo_peripheral_model
(
    input wire logic [2:0] mode_i,
    output ppo_pkg::ppo_override_t override_o [8]
);
    import ppo_pkg::*;

    // Each peripheral forms its own enables and values per pin.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            override_o[i] = '0;
            override_o[i].pullup_override_en = (mode_i == 3'h1);
            override_o[i].pullup_override_val = ~i[0];
            override_o[i].direction_override_en = (mode_i == 3'h2);
            override_o[i].direction_override_val = i[0];
            override_o[i].value_override_en = (mode_i == 3'h3);
            override_o[i].value_override_val = (i < 4);
            override_o[i].input_enable_override_en = (mode_i == 3'h4);
            override_o[i].input_enable_override_val = 1'b1;
            override_o[i].toggle_override_en = (mode_i == 3'h5) && (i == 0);
        end
    end
endmodule

//--- sim/testbench.sv
// Self-checking bench of the port pin override logic.
// Assumes the pad level is resolved here from drive enables.
`timescale 1ns/1ps

module testbench;
    import ppo_pkg::*;

    logic clk = 1'b0, rst = 1'b1, dws = 1'b0, ows = 1'b0, iws = 1'b0;
    logic rs = 1'b0, slp = 1'b0, global_pullup_disable = 1'b0, osc;
    logic [7:0] wd = 8'h00, ext = 8'h00, ie = 8'h00, pin, po, oe, pu;
    logic [7:0] raw, pcs, dirb, outb, inb, rdd;
    logic [2:0] mode = 3'h0;
    ppo_read_sel_t sel = PPO_RD_DIRECTION;
    ppo_clock_cfg_t cfg = '0;
    ppo_override_t ov [8];
    int err_count = 0, samples_checked = 0, cycles = 0;

    // Driven pins show their own value, the rest the outside level.
    assign pin = (oe & po) | (~oe & ext);
    always #20 clk = ~clk;

    ppo_peripheral_model u_ppo_peripheral_model (.mode_i(mode),
        .override_o(ov));
    ppo_port_pin_override u_ppo_port_pin_override (.clk_sys_i(clk),
        .rst_i(rst), .dir_write_strobe_i(dws), .out_write_strobe_i(ows),
        .in_write_strobe_i(iws), .write_data_i(wd),
        .port_read_strobe_i(rs), .read_sel_i(sel), .read_data_o(rdd),
        .sleep_i(slp), .global_pullup_disable_i(global_pullup_disable), .clock_cfg_i(cfg),
        .override_i(ov), .ext_int_enable_i(ie), .pad_in_i(pin),
        .pad_out_o(po), .pad_oe_o(oe), .pullup_en_o(pu),
        .raw_digital_input_o(raw), .pin_change_source_o(pcs),
        .osc_amp_output_o(osc), .pin_direction_bit_o(dirb),
        .pin_output_bit_o(outb), .pin_input_bit_o(inb));

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic close_out();
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Kind 0 writes direction, 1 output, 2 toggles through the input.
    task automatic wr(input int k, input logic [7:0] d);
        @(posedge clk);
        wd <= d;
        dws <= (k == 0);
        ows <= (k == 1);
        iws <= (k == 2);
        @(posedge clk);
        dws <= 1'b0;
        ows <= 1'b0;
        iws <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        @(posedge clk);
        rs <= 1'b1;
        sel <= ppo_read_sel_t'(s);
        @(posedge clk);
        rs <= 1'b0;
        @(negedge clk);
        check(rdd, e);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(dirb | oe, 8'h00);
        wr(1, 8'hFF);
        check(pu, 8'hFF);
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        check(pu, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check(outb, 8'h00);
        wr(1, 8'hFF);
        wr(0, 8'h0F);
        check(pu, 8'hF0);
        check(oe, 8'h0F);
        @(posedge clk);
        global_pullup_disable <= 1'b1;
        @(negedge clk);
        check(pu, 8'h00);
        wr(2, 8'h3C);
        rd(2'h1, 8'hC3);
        rd(2'h0, 8'h0F);
        check(po, 8'h03);
        @(posedge clk);
        global_pullup_disable <= 1'b0;
        ext <= 8'hA5;
        @(negedge clk);
        check(pcs, 8'hA3);
        rd(2'h2, 8'hA3);
        @(posedge clk);
        slp <= 1'b1;
        ie <= 8'h80;
        @(negedge clk);
        check(raw, 8'h80);
        @(posedge clk);
        slp <= 1'b0;
        @(negedge clk);
        check(raw, 8'hA3);
        @(posedge clk);
        slp <= 1'b1;
        mode <= 3'h4;
        @(negedge clk);
        check(raw, 8'hA3);
        @(posedge clk);
        mode <= 3'h1;
        slp <= 1'b0;
        @(negedge clk);
        check(pu, 8'h55);
        @(posedge clk);
        mode <= 3'h2;
        @(negedge clk);
        check(oe, 8'hAA);
        @(posedge clk);
        mode <= 3'h3;
        @(negedge clk);
        check(po, 8'h0F);
        rd(2'h1, 8'hC3);
        @(posedge clk);
        mode <= 3'h5;
        @(posedge clk);
        mode <= 3'h0;
        @(negedge clk);
        check(outb, 8'hC2);
        wr(0, 8'hFF);
        @(posedge clk);
        cfg <= 4'h8;
        @(negedge clk);
        check(oe, 8'h7F);
        rd(2'h0, 8'h7F);
        rd(2'h1, 8'h42);
        rd(2'h2, 8'h42);
        rd(2'h3, 8'h00);
        @(posedge clk);
        cfg <= 4'h6;
        @(negedge clk);
        check({7'h00, osc}, 8'h01);
        @(posedge clk);
        cfg <= 4'h7;
        @(negedge clk);
        check({7'h00, osc}, 8'h00);
        close_out();
    end
endmodule
